// File: hdl/ppc_top.sv
// Behaviour
// - controller-port direction bit set makes pin output, clear makes input.
// - controller-port pins come out of reset as inputs.
// - controller-port data top bit reads 0 unless its direction bit is set.
// - controller-port pullup bit pulls up every input pin among controller-port pins 6 to 2.
// - controller-port low-drive bit reduces drive; resets to normal; writable anytime.
// - eight input-only analog pins, general inputs while converter is off.
// - enabled modulator channel overrides general-purpose use of its pin.
// - pulse-width port direction bit makes output; reset clears all to inputs.
// - pulse-width pullup bit pulls up its input pins; off after reset.
// - pulse-width low-drive bit reduces all outputs; full drive after reset.
// - timer port pins general-purpose except where timer functions claim them.
// - timer port direction bit makes output; reset clears all to inputs.
// - timer pullup bit covers all timer input pins, low-drive bit all timer pins; off at reset.
// - async open-drain bit disables high drivers of serial bits 0 to 3.
// - sync open-drain bit disables high drivers of bits 4 to 7.
// - serial pullup group bit acts only on undriven pins, port or peripheral inputs alike.
// - each serial low-drive group bit reduces drive of its group's pins.
`timescale 1ns/10ps
`default_nettype none
module ppc_top
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // avalon-mm slave, byte addressed
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // pin levels from the pads
   input  wire logic [7:0]  ctrl_port_pins_in,
   input  wire logic [7:0]  pwm_pins_in,
   input  wire logic [7:0]  timer_pins_in,
   input  wire logic [7:0]  serial_pins_in,
   input  wire logic [7:0]  analog_input_pins,
   // sharing peripherals, same clock
   input  wire logic [3:0]  pwm_wave,
   input  wire ppc_periph_s timer_periph,
   input  wire ppc_periph_s serial_periph,
   // pad controls
   output ppc_pad_s         ctrl_pad,
   output ppc_pad_s         pwm_pad,
   output ppc_pad_s         timer_pad,
   output ppc_pad_s         serial_pad
);

   // software registers
   logic [7:0] pullup_control_q;
   logic [7:0] reduced_drive_control_q;
   logic [7:0] pwm_port_control_q;
   logic [7:0] timer_mask_two_q;
   logic [7:0] serial_port_pull_drive_q;
   logic [7:0] link_port_control_q;
   logic [7:0] periph_share_q;
   logic [3:0] modulator_channel_enable_q;
   logic [7:0] ctrl_port_data_q;
   logic [7:0] ctrl_port_direction_q;
   logic [7:0] pwm_port_data_q;
   logic [7:0] pwm_port_direction_q;
   logic [7:0] timer_port_data_q;
   logic [7:0] timer_port_direction_q;
   logic [7:0] serial_port_data_q;
   logic [7:0] serial_port_direction_q;

   // bus handshake state
   logic       wait_q;

   // synchronised pin levels
   logic [7:0] ctrl_sync;
   logic [7:0] pwm_sync;
   logic [7:0] timer_sync;
   logic [7:0] serial_sync;
   logic [7:0] analog_sync;

   // pins cross into this clock through two stages
   ppc_sync #(.W(40)) u_sync (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .async_in ({ctrl_port_pins_in, pwm_pins_in, timer_pins_in,
                  serial_pins_in, analog_input_pins}),
      .sync_out ({ctrl_sync, pwm_sync, timer_sync, serial_sync,
                  analog_sync})
   );

   // bus decode
   wire [7:0] reg_idx  = avs_address[9:2];
   wire       req      = avs_read | avs_write;
   wire       wr_en    = avs_write & ~wait_q & avs_byteenable[0];
   wire [7:0] wr_byte  = avs_writedata[7:0];
   wire       wr_pullup_control  = wr_en & (reg_idx == PPC_IDX_PULLUP_CONTROL);
   wire       wr_rdrv  = wr_en & (reg_idx == PPC_IDX_REDUCED_DRIVE);
   wire       wr_pwm_port_control = wr_en & (reg_idx == PPC_IDX_PWM_PORT_CTRL);
   wire       wr_pwdat = wr_en & (reg_idx == PPC_IDX_PWM_PORT_DATA);
   wire       wr_pwdir = wr_en & (reg_idx == PPC_IDX_PWM_PORT_DIR);
   wire       wr_tmsk  = wr_en & (reg_idx == PPC_IDX_TIMER_MASK_TWO);
   wire       wr_tdat  = wr_en & (reg_idx == PPC_IDX_TIMER_DATA);
   wire       wr_tdir  = wr_en & (reg_idx == PPC_IDX_TIMER_DIR);
   wire       wr_sdat  = wr_en & (reg_idx == PPC_IDX_SERIAL_DATA);
   wire       wr_sdir  = wr_en & (reg_idx == PPC_IDX_SERIAL_DIR);
   wire       wr_spd   = wr_en & (reg_idx == PPC_IDX_SERIAL_PULL_DRV);
   wire       wr_share = wr_en & (reg_idx == PPC_IDX_PERIPH_SHARE);
   wire       wr_men   = wr_en & (reg_idx == PPC_IDX_MOD_CHAN_EN);
   wire       wr_link  = wr_en & (reg_idx == PPC_IDX_LINK_PORT_CTRL);
   wire       wr_cdat  = wr_en & (reg_idx == PPC_IDX_CTRL_DATA);
   wire       wr_cdir  = wr_en & (reg_idx == PPC_IDX_CTRL_DIR);

   // port read values: outputs give the latch, inputs the pin
   wire [7:0] pwm_rd    = (pwm_port_direction_q & pwm_port_data_q) |
                          (~pwm_port_direction_q & pwm_sync);
   wire [7:0] timer_rd  = (timer_port_direction_q & timer_port_data_q) |
                          (~timer_port_direction_q & timer_sync);
   wire [7:0] serial_rd = (serial_port_direction_q & serial_port_data_q) |
                          (~serial_port_direction_q & serial_sync);
   wire [7:0] ctrl_mid  = ((ctrl_port_direction_q & ctrl_port_data_q) |
                          (~ctrl_port_direction_q & ctrl_sync)) &
                          PPC_MASK_CTRL_PINS;
   // top bit has no pin: latch shows only while its direction bit is set
   wire       ctrl_top  = ctrl_port_direction_q[PPC_CTRL_TOP] &
                          ctrl_port_data_q[PPC_CTRL_TOP];
   wire [7:0] ctrl_rd   = {ctrl_top, ctrl_mid[6:0]};
   // analog pins read as general inputs only while converter is off
   wire [7:0] analog_rd = periph_share_q[PPC_BIT_CONV_POWER] ?
                          PPC_RST_ZERO : analog_sync;

   // read multiplexer; unmapped indices read zero
   logic [7:0] rd_byte;
   always_comb begin
      unique case (reg_idx)
         PPC_IDX_PULLUP_CONTROL:  rd_byte = pullup_control_q;
         PPC_IDX_REDUCED_DRIVE:   rd_byte = reduced_drive_control_q;
         PPC_IDX_PWM_PORT_CTRL:   rd_byte = pwm_port_control_q;
         PPC_IDX_PWM_PORT_DATA:   rd_byte = pwm_rd;
         PPC_IDX_PWM_PORT_DIR:    rd_byte = pwm_port_direction_q;
         PPC_IDX_ANALOG_DATA:     rd_byte = analog_rd;
         PPC_IDX_TIMER_MASK_TWO:  rd_byte = timer_mask_two_q;
         PPC_IDX_TIMER_DATA:      rd_byte = timer_rd;
         PPC_IDX_TIMER_DIR:       rd_byte = timer_port_direction_q;
         PPC_IDX_SERIAL_DATA:     rd_byte = serial_rd;
         PPC_IDX_SERIAL_DIR:      rd_byte = serial_port_direction_q;
         PPC_IDX_SERIAL_PULL_DRV: rd_byte = serial_port_pull_drive_q;
         PPC_IDX_PERIPH_SHARE:    rd_byte = periph_share_q;
         PPC_IDX_MOD_CHAN_EN:     rd_byte = {4'h0, modulator_channel_enable_q};
         PPC_IDX_LINK_PORT_CTRL:  rd_byte = link_port_control_q;
         PPC_IDX_CTRL_DATA:       rd_byte = ctrl_rd;
         PPC_IDX_CTRL_DIR:        rd_byte = ctrl_port_direction_q;
         default:                 rd_byte = PPC_RST_ZERO;
      endcase
   end

   // one wait cycle per access: read data is sampled while waitrequest is high, writes land once it is low
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wait_q       <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         if (req && wait_q) begin
            wait_q       <= 1'b0;
            avs_readdata <= {24'h00_0000, rd_byte};
         end else begin
            wait_q       <= 1'b1;
         end
      end
   end
   assign avs_waitrequest = wait_q;

   // configuration registers; all writable at any time after reset
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pullup_control_q           <= PPC_RST_PULLUP_CONTROL;
         reduced_drive_control_q    <= PPC_RST_ZERO;
         pwm_port_control_q         <= PPC_RST_ZERO;
         timer_mask_two_q           <= PPC_RST_ZERO;
         serial_port_pull_drive_q   <= PPC_RST_ZERO;
         link_port_control_q        <= PPC_RST_ZERO;
         periph_share_q             <= PPC_RST_ZERO;
         modulator_channel_enable_q <= 4'h0;
      end else begin
         if (wr_pullup_control)
            pullup_control_q <= wr_byte & PPC_MASK_PULLUP_CONTROL;
         if (wr_rdrv)
            reduced_drive_control_q <= wr_byte & PPC_MASK_REDUCED_DRIVE;
         if (wr_pwm_port_control)
            pwm_port_control_q <= wr_byte;
         if (wr_tmsk)
            timer_mask_two_q <= wr_byte;
         if (wr_spd)
            serial_port_pull_drive_q <= wr_byte;
         if (wr_link)
            link_port_control_q <= wr_byte;
         if (wr_share)
            periph_share_q <= wr_byte;
         if (wr_men)
            modulator_channel_enable_q <= wr_byte[3:0];
      end
   end

   // port data latches and direction registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_port_data_q        <= PPC_RST_ZERO;
         ctrl_port_direction_q   <= PPC_RST_ZERO;
         pwm_port_data_q         <= PPC_RST_ZERO;
         pwm_port_direction_q    <= PPC_RST_ZERO;
         timer_port_data_q       <= PPC_RST_ZERO;
         timer_port_direction_q  <= PPC_RST_ZERO;
         serial_port_data_q      <= PPC_RST_ZERO;
         serial_port_direction_q <= PPC_RST_ZERO;
      end else begin
         if (wr_cdat)
            ctrl_port_data_q <= wr_byte & PPC_MASK_CTRL_DATA;
         if (wr_cdir)
            ctrl_port_direction_q <= wr_byte & PPC_MASK_CTRL_DATA;
         if (wr_pwdat)
            pwm_port_data_q <= wr_byte;
         if (wr_pwdir)
            pwm_port_direction_q <= wr_byte;
         if (wr_tdat)
            timer_port_data_q <= wr_byte;
         if (wr_tdir)
            timer_port_direction_q <= wr_byte;
         if (wr_sdat)
            serial_port_data_q <= wr_byte;
         if (wr_sdir)
            serial_port_direction_q <= wr_byte;
      end
   end

   // group controls fanned out to pins
   wire       ctrl_pull  = link_port_control_q[PPC_BIT_LINK_PULLUP];
   wire       ctrl_ldrv  = link_port_control_q[PPC_BIT_LINK_LOW_DRV];
   wire       pwm_pull   = pwm_port_control_q[PPC_BIT_PWM_PULLUP];
   wire       pwm_ldrv   = pwm_port_control_q[PPC_BIT_PWM_LOW_DRV];
   wire       tmr_pull   = timer_mask_two_q[PPC_BIT_TMR_PULLUP];
   wire       tmr_ldrv   = timer_mask_two_q[PPC_BIT_TMR_LOW_DRV];
   wire [2:0] ser_pull   = serial_port_pull_drive_q[PPC_BIT_SER_PULL0 +: 3];
   wire [2:0] ser_ldrv   = serial_port_pull_drive_q[PPC_BIT_SER_DRV0 +: 3];
   wire       async_od   = periph_share_q[PPC_BIT_ASYNC_OD];
   wire       sync_od    = periph_share_q[PPC_BIT_SYNC_OD];
   // timer pins are only taken while a timer function is on
   wire       tmr_active = periph_share_q[PPC_BIT_TIMER_EN] |
                           periph_share_q[PPC_BIT_PACC_EN];

   // controller port: pins 6..2 only, the rest never driven
   wire [7:0] ctrl_dir_pins = ctrl_port_direction_q & PPC_MASK_CTRL_PINS;
   wire [7:0] ctrl_pull_v   = {8{ctrl_pull}} & PPC_MASK_CTRL_PINS;
   wire [7:0] ctrl_ldrv_v   = {8{ctrl_ldrv}} & PPC_MASK_CTRL_PINS;

   // modulator channels claim pins 3..0 while enabled
   wire ppc_periph_s pwm_periph = '{
      claim: {4'h0, modulator_channel_enable_q},
      out:   {4'h0, pwm_wave},
      oe:    {4'h0, modulator_channel_enable_q}
   };

   wire ppc_periph_s tmr_periph = '{
      claim: timer_periph.claim & {8{tmr_active}},
      out:   timer_periph.out,
      oe:    timer_periph.oe
   };

   // serial groups: 1..0, 3..2, 7..4
   wire [7:0] ser_pull_v = {{4{ser_pull[2]}}, {2{ser_pull[1]}},
                            {2{ser_pull[0]}}};
   wire [7:0] ser_ldrv_v = {{4{ser_ldrv[2]}}, {2{ser_ldrv[1]}},
                            {2{ser_ldrv[0]}}};
   wire [7:0] ser_od_v   = {{4{sync_od}}, {4{async_od}}};

   ppc_pin_cell u_ctrl (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .dir        (ctrl_dir_pins),
      .data       (ctrl_port_data_q),
      .open_drain (PPC_RST_ZERO),
      .pull_req   (ctrl_pull_v),
      .low_drv    (ctrl_ldrv_v),
      .periph     ('0),
      .pad        (ctrl_pad)
   );

   ppc_pin_cell u_pwm (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .dir        (pwm_port_direction_q),
      .data       (pwm_port_data_q),
      .open_drain (PPC_RST_ZERO),
      .pull_req   ({8{pwm_pull}}),
      .low_drv    ({8{pwm_ldrv}}),
      .periph     (pwm_periph),
      .pad        (pwm_pad)
   );

   ppc_pin_cell u_timer (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .dir        (timer_port_direction_q),
      .data       (timer_port_data_q),
      .open_drain (PPC_RST_ZERO),
      .pull_req   ({8{tmr_pull}}),
      .low_drv    ({8{tmr_ldrv}}),
      .periph     (tmr_periph),
      .pad        (timer_pad)
   );

   ppc_pin_cell u_serial (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .dir        (serial_port_direction_q),
      .data       (serial_port_data_q),
      .open_drain (ser_od_v),
      .pull_req   (ser_pull_v),
      .low_drv    (ser_ldrv_v),
      .periph     (serial_periph),
      .pad        (serial_pad)
   );

endmodule // ppc_top
`default_nettype wire

// File: hdl/ppc_pkg.sv
package ppc_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] PPC_IDX_PULLUP_CONTROL  = 8'h0C;
   localparam logic [7:0] PPC_IDX_REDUCED_DRIVE   = 8'h0D;
   localparam logic [7:0] PPC_IDX_PWM_PORT_CTRL   = 8'h54;
   localparam logic [7:0] PPC_IDX_PWM_PORT_DATA   = 8'h56;
   localparam logic [7:0] PPC_IDX_PWM_PORT_DIR    = 8'h57;
   localparam logic [7:0] PPC_IDX_ANALOG_DATA     = 8'h6F;
   localparam logic [7:0] PPC_IDX_TIMER_MASK_TWO  = 8'h8D;
   localparam logic [7:0] PPC_IDX_TIMER_DATA      = 8'hAE;
   localparam logic [7:0] PPC_IDX_TIMER_DIR       = 8'hAF;
   localparam logic [7:0] PPC_IDX_SERIAL_DATA     = 8'hD6;
   localparam logic [7:0] PPC_IDX_SERIAL_DIR      = 8'hD7;
   localparam logic [7:0] PPC_IDX_SERIAL_PULL_DRV = 8'hDB;
   localparam logic [7:0] PPC_IDX_PERIPH_SHARE    = 8'hF0;
   localparam logic [7:0] PPC_IDX_MOD_CHAN_EN     = 8'hF1;
   localparam logic [7:0] PPC_IDX_LINK_PORT_CTRL  = 8'hFD;
   localparam logic [7:0] PPC_IDX_CTRL_DATA       = 8'hFE;
   localparam logic [7:0] PPC_IDX_CTRL_DIR        = 8'hFF;

   // implemented bits per register
   localparam logic [7:0] PPC_MASK_PULLUP_CONTROL = 8'h13;
   localparam logic [7:0] PPC_MASK_REDUCED_DRIVE  = 8'h0B;
   localparam logic [7:0] PPC_MASK_CTRL_PINS      = 8'h7C;
   localparam logic [7:0] PPC_MASK_CTRL_DATA      = 8'hFC;

   // reset values
   localparam logic [7:0] PPC_RST_PULLUP_CONTROL  = 8'h10;
   localparam logic [7:0] PPC_RST_ZERO            = 8'h00;

   // field positions
   localparam int PPC_BIT_PWM_PULLUP   = 3;
   localparam int PPC_BIT_PWM_LOW_DRV  = 2;
   localparam int PPC_BIT_TMR_PULLUP   = 5;
   localparam int PPC_BIT_TMR_LOW_DRV  = 4;
   localparam int PPC_BIT_SER_PULL0    = 0;
   localparam int PPC_BIT_SER_DRV0     = 4;
   localparam int PPC_BIT_LINK_PULLUP  = 1;
   localparam int PPC_BIT_LINK_LOW_DRV = 0;
   localparam int PPC_BIT_CONV_POWER   = 0;
   localparam int PPC_BIT_ASYNC_OD     = 1;
   localparam int PPC_BIT_SYNC_OD      = 2;
   localparam int PPC_BIT_TIMER_EN     = 3;
   localparam int PPC_BIT_PACC_EN      = 4;
   localparam int PPC_CTRL_TOP         = 7;

   // per-port pad controls, one bit per pin
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pull_en;
      logic [7:0] low_drv;
   } ppc_pad_s;

   // peripheral claim on a port's pins
   typedef struct packed {
      logic [7:0] claim;
      logic [7:0] out;
      logic [7:0] oe;
   } ppc_periph_s;

endpackage

// File: hdl/ppc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   // asynchronous in, synchronised out
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // two stages; first stage feeds only the second
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // ppc_sync
`default_nettype wire

// File: hdl/ppc_pin_cell.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_pin_cell
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // software settings
   input  wire logic [7:0]  dir,
   input  wire logic [7:0]  data,
   input  wire logic [7:0]  open_drain,
   input  wire logic [7:0]  pull_req,
   input  wire logic [7:0]  low_drv,
   // sharing peripheral
   input  wire ppc_periph_s periph,
   // registered pad controls
   output var  ppc_pad_s    pad
);

   logic [7:0] drive;
   logic [7:0] value;
   logic [7:0] oe_n_d;
   logic [7:0] pull_d;

   // one cell per pin; an enabled peripheral owns its pin over the port
   for (genvar i = 0; i < 8; i++) begin : g_pin
      assign drive[i] = periph.claim[i] ? periph.oe[i]  : dir[i];
      assign value[i] = periph.claim[i] ? periph.out[i] : data[i];
      // open drain: a high is released, not driven
      assign oe_n_d[i] = ~(drive[i] &
                           ~(open_drain[i] & value[i]));
      assign pull_d[i] = pull_req[i] & ~drive[i];
   end

   // one register process, so the pad struct has a single driver
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pad <= '{out: '0, oe_n: '1, pull_en: '0, low_drv: '0};
      end else begin
         pad <= '{out: value, oe_n: oe_n_d, pull_en: pull_d,
                  low_drv: low_drv};
      end
   end

endmodule // ppc_pin_cell
`default_nettype wire

// File: sim/ppc_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_sva
   import ppc_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        nrst,
   // register bus
   input wire logic [9:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // pad controls
   input wire ppc_pad_s    ctrl_pad,
   input wire ppc_pad_s    pwm_pad,
   input wire ppc_pad_s    timer_pad,
   input wire ppc_pad_s    serial_pad
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // write taking effect at this edge
   sequence s_wr(logic [7:0] idx);
      avs_write && !avs_waitrequest && avs_byteenable[0]
         && avs_address[9:2] == idx;
   endsequence
   // one wait state, then idle high again
   sequence s_answer;
      ##1 !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   AST_BUS_ONE_WAIT:
      assert property ((avs_read || avs_write) && avs_waitrequest |-> s_answer)
      else $error("bus wait state");
   AST_RST_INPUTS:
      assert property ($rose(nrst) |-> (ctrl_pad.oe_n & pwm_pad.oe_n
         & timer_pad.oe_n) == 8'hFF && (pwm_pad.pull_en | timer_pad.pull_en
         | ctrl_pad.low_drv) == 8'h00) else $error("pads not idle at reset");
   AST_CTRL_DIR:
      assert property (s_wr(PPC_IDX_CTRL_DIR) |-> ##2
         ctrl_pad.oe_n[6:2] == ~$past(avs_writedata[6:2], 2))
      else $error("ctrl direction");
   AST_CTRL_FIXED:
      assert property (&{ctrl_pad.oe_n[7], ctrl_pad.oe_n[1:0]})
      else $error("ctrl pin driven");
   AST_CTRL_DRV:
      assert property (s_wr(PPC_IDX_LINK_PORT_CTRL) |-> ##2
         ctrl_pad.low_drv[6:2] == {5{$past(avs_writedata[0], 2)}})
      else $error("ctrl low drive wrong");
   AST_PWM_CTRL:
      assert property (s_wr(PPC_IDX_PWM_PORT_CTRL) |-> ##2
         pwm_pad.low_drv == {8{$past(avs_writedata[2], 2)}} && pwm_pad.pull_en
         == ({8{$past(avs_writedata[3], 2)}} & pwm_pad.oe_n))
      else $error("pwm pull/drive");
   AST_TMR_CTRL:
      assert property (s_wr(PPC_IDX_TIMER_MASK_TWO) |-> ##2
         timer_pad.low_drv == {8{$past(avs_writedata[4], 2)}} && timer_pad.pull_en
         == ({8{$past(avs_writedata[5], 2)}} & timer_pad.oe_n))
      else $error("timer pull/drive");
   AST_PULL_INPUT:
      assert property (((serial_pad.pull_en & ~serial_pad.oe_n)
         | (ctrl_pad.pull_en & ~ctrl_pad.oe_n)) == 8'h00)
      else $error("pullup on a driven pin");
   AST_READ_CTRL:
      assert property (avs_read && !avs_waitrequest && avs_address[9:2]
         == PPC_IDX_CTRL_DATA |-> avs_readdata[1:0] == 2'b00
         && avs_readdata[31:8] == 24'h00_0000) else $error("ctrl read bits");
endmodule // ppc_sva
bind ppc_top ppc_sva u_ppc_sva (.*);
`default_nettype wire

// File: sim/ppc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_pin_model
   import ppc_pkg::*;
(
   // clock
   input  wire logic       ref_clk,
   // pad controls and outside drivers
   input  wire ppc_pad_s   pad,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   // resolved pin level
   output logic      [7:0] pin
);
   logic [7:0] float_q = 8'h5A;
   // floating pins wander so no stale level is read back
   always_ff @(posedge ref_clk) begin
      float_q <= ~float_q;
   end
   // pad drive wins, then outside driver, then pullup, else floating
   assign pin = (~pad.oe_n & pad.out) | (pad.oe_n & ext_en & ext_val)
      | (pad.oe_n & ~ext_en & (pad.pull_en | float_q));
endmodule // ppc_pin_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
   import ppc_pkg::*;
;
   logic ref_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [9:0]  avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata;
   logic [3:0]  avs_byteenable = 4'hF, pwm_wave = 4'h2;
   logic        avs_waitrequest;
   logic [7:0]  ctrl_pins, pwm_pins, timer_pins, serial_pins;
   logic [7:0]  analog_pins = 8'hA5, ext_en = 8'h00, ext_val = 8'h00;
   ppc_periph_s timer_periph = {8'h01, 8'h01, 8'h01};
   ppc_periph_s serial_periph = '0;
   ppc_pad_s    ctrl_pad, pwm_pad, timer_pad, serial_pad;
   int n_fail = 0, tests_run = 0;
   ppc_top u_ppc_top (.ref_clk, .nrst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .ctrl_port_pins_in(ctrl_pins), .pwm_pins_in(pwm_pins),
      .timer_pins_in(timer_pins), .serial_pins_in(serial_pins),
      .analog_input_pins(analog_pins), .pwm_wave, .timer_periph,
      .serial_periph, .ctrl_pad, .pwm_pad, .timer_pad, .serial_pad);
   // outside circuitry; ctrl and serial pins share the outside driver
   ppc_pin_model u_ctrl_pins (.ref_clk, .pad(ctrl_pad), .ext_en, .ext_val,
      .pin(ctrl_pins));
   ppc_pin_model u_pwm_pins (.ref_clk, .pad(pwm_pad), .ext_en(8'h00),
      .ext_val(8'h00), .pin(pwm_pins));
   ppc_pin_model u_tmr_pins (.ref_clk, .pad(timer_pad), .ext_en(8'h00),
      .ext_val(8'h00), .pin(timer_pins));
   ppc_pin_model u_ser_pins (.ref_clk, .pad(serial_pad), .ext_en, .ext_val,
      .pin(serial_pins));
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one access; request held until waitrequest is seen low
   task automatic bus(input logic rd, input logic [7:0] idx, wd,
                      output logic [31:0] rdat);
      int i;
      @(posedge ref_clk);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h00_0000, wd};
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i == 20) begin
         n_fail++;
         print_verdict();
      end
   endtask
   // pads settle one edge after the register lands
   task automatic wr(input logic [7:0] idx, wd);
      logic [31:0] v;
      bus(1'b0, idx, wd, v);
      @(posedge ref_clk);
      #1;
   endtask
   // extra edges cover the two-flop pin synchroniser
   task automatic rd(input logic [7:0] idx, output logic [31:0] v);
      repeat (4) @(posedge ref_clk);
      bus(1'b1, idx, 8'h00, v);
   endtask
   task automatic t_reset();
      logic [7:0] regs [6] = '{PPC_IDX_PULLUP_CONTROL, PPC_IDX_REDUCED_DRIVE,
         PPC_IDX_PWM_PORT_CTRL, PPC_IDX_TIMER_MASK_TWO,
         PPC_IDX_SERIAL_PULL_DRV, PPC_IDX_LINK_PORT_CTRL};
      logic [31:0] v;
      chk("oe_n", ctrl_pad.oe_n & pwm_pad.oe_n & timer_pad.oe_n, 8'hFF);
      foreach (regs[k]) begin
         rd(regs[k], v);
         chk("reset value", v, k == 0 ? 32'h0000_0010 : 32'h0000_0000);
      end
   endtask
   task automatic t_ctrl();
      logic [31:0] v;
      wr(PPC_IDX_CTRL_DIR, 8'h7C);
      wr(PPC_IDX_CTRL_DATA, 8'hA8);
      chk("ctrl oe_n", ctrl_pad.oe_n, 8'h83);
      chk("ctrl out", ctrl_pad.out & 8'h7C, 8'h28);
      rd(PPC_IDX_CTRL_DATA, v);
      chk("ctrl read dir7 low", v, 32'h0000_0028);
      wr(PPC_IDX_CTRL_DIR, 8'h80);
      wr(PPC_IDX_LINK_PORT_CTRL, 8'h03);
      chk("ctrl pull", ctrl_pad.pull_en & 8'h7C, 8'h7C);
      chk("ctrl low", ctrl_pad.low_drv & 8'h7C, 8'h7C);
      rd(PPC_IDX_CTRL_DATA, v);
      chk("ctrl read pulled", v, 32'h0000_00FC);
      ext_en = 8'hFF;
      ext_val = 8'h14;
      rd(PPC_IDX_CTRL_DATA, v);
      chk("ctrl read pins", v, 32'h0000_0094);
   endtask
   task automatic t_pwm();
      wr(PPC_IDX_PWM_PORT_DIR, 8'h0F);
      wr(PPC_IDX_PWM_PORT_DATA, 8'h05);
      wr(PPC_IDX_PWM_PORT_CTRL, 8'h0C);
      chk("pwm oe_n", pwm_pad.oe_n, 8'hF0);
      chk("pwm out", pwm_pad.out & 8'h0F, 8'h05);
      chk("pwm pull", pwm_pad.pull_en, 8'hF0);
      chk("pwm low", pwm_pad.low_drv, 8'hFF);
      wr(PPC_IDX_PWM_PORT_DIR, 8'h00);
      wr(PPC_IDX_MOD_CHAN_EN, 8'h0A);
      chk("pwm chan oe_n", pwm_pad.oe_n, 8'hF5);
      chk("pwm chan out", pwm_pad.out & 8'h0A, 8'h02);
      wr(PPC_IDX_MOD_CHAN_EN, 8'h00);
      chk("pwm chan off", pwm_pad.oe_n, 8'hFF);
   endtask
   task automatic t_timer();
      logic [7:0] ens [2] = '{8'h08, 8'h10};
      logic [31:0] v;
      wr(PPC_IDX_TIMER_DIR, 8'h81);
      wr(PPC_IDX_TIMER_DATA, 8'h00);
      chk("tmr oe_n", timer_pad.oe_n, 8'h7E);
      chk("tmr free", timer_pad.out & 8'h81, 8'h00);
      foreach (ens[k]) begin
         wr(PPC_IDX_PERIPH_SHARE, ens[k]);
         chk("tmr claim", timer_pad.out & 8'h81, 8'h01);
      end
      wr(PPC_IDX_TIMER_MASK_TWO, 8'h30);
      chk("tmr pull", timer_pad.pull_en, 8'h7E);
      chk("tmr low", timer_pad.low_drv, 8'hFF);
      rd(PPC_IDX_TIMER_DATA, v);
      chk("tmr read", v, 32'h0000_007E);
   endtask
   task automatic t_serial();
      logic [23:0] od [5] = '{24'h00_FF00, 24'h02_FF0F, 24'h04_FFF0,
         24'h06_FFFF, 24'h06_0000};
      logic [31:0] v;
      wr(PPC_IDX_SERIAL_DIR, 8'hFF);
      foreach (od[k]) begin
         wr(PPC_IDX_PERIPH_SHARE, od[k][23:16]);
         wr(PPC_IDX_SERIAL_DATA, od[k][15:8]);
         chk("ser open drain", serial_pad.oe_n, od[k][7:0]);
      end
      wr(PPC_IDX_SERIAL_DIR, 8'h0C);
      wr(PPC_IDX_SERIAL_PULL_DRV, 8'h17);
      chk("ser pull", serial_pad.pull_en, 8'hF3);
      chk("ser low", serial_pad.low_drv, 8'h03);
      wr(PPC_IDX_SERIAL_PULL_DRV, 8'h62);
      chk("ser pull out", serial_pad.pull_en, 8'h00);
      chk("ser low", serial_pad.low_drv, 8'hFC);
      rd(PPC_IDX_ANALOG_DATA, v);
      chk("analog", v, 32'h0000_00A5);
      wr(PPC_IDX_PERIPH_SHARE, 8'h01);
      rd(PPC_IDX_ANALOG_DATA, v);
      chk("analog powered", v, 32'h0000_0000);
      rd(8'h01, v);
      chk("unmapped", v, 32'h0000_0000);
      @(posedge ref_clk);
      avs_byteenable <= 4'h0;
      wr(PPC_IDX_CTRL_DIR, 8'hFC);
      chk("no byte lane", ctrl_pad.oe_n, 8'hFF);
      avs_byteenable <= 4'hF;
   endtask
   // main sequence, with a second reset after the port tests
   initial begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      t_ctrl();
      t_pwm();
      t_timer();
      t_serial();
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      print_verdict();
   end
endmodule // tb
`default_nettype wire
